// [hw/rco_relay_card.v]
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rco_defs.vh"
// How it works
// - after power up, wait fifteen seconds before relays show status
// - init done lights bus led, then relays and leds follow status
// - normal condition keeps each relay energized, fail-safe
// - programmed trouble or alarm turns led off and drops relay
// - faults, invalid config, disable, pressure, low voltage, activation trip
// - four mode switches pick one of six fixed mappings
// - two address switches give the card its bus identity
// - single switch change ignored; new mode needs clear position first
// - twelve software-loaded mapping profiles selectable besides switch modes
// - each relay can follow any one of 65 events
// - eleven events tracked separately for each of four controllers
// - supply unit events and status bus failure recognised
// - card listens and reports on the low speed status bus
// - remote de-energize commands accepted over the status bus
module rco_relay_card #(
    parameter [31:0] INIT_CYCLES = `RCO_INIT_S * `RCO_CLK_HZ,
    parameter [31:0] BUS_TIMEOUT = `RCO_BUS_TIMEOUT_MS * (`RCO_CLK_HZ / 1000)
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // switches and supply sense
    input wire [3:0] mode_sw,
    input wire [1:0] addr_sw,
    input wire supply_low,
    // status bus receive
    input wire sb_rx_valid,
    input wire [3:0] sb_rx_src,
    input wire [15:0] sb_rx_data,
    // status bus transmit
    output reg sb_tx_valid,
    output reg [3:0] sb_tx_src,
    output reg [15:0] sb_tx_data,
    // relays and indicators
    output reg [7:0] relay_drive,
    output reg [7:0] relay_led,
    output reg bus_led,
    // axi4-lite write
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // ****************************************
    // mapping functions
    // ****************************************
    function [6:0] slot_index;
        input [3:0] slot;
        input [1:0] c;
        reg [6:0] b;
        begin
            b = {5'h00, c} * 7'd11;
            case (slot)
                4'h0: slot_index = `RCO_EV_TRB_BASE + {5'h00, c};
                4'h1: slot_index = `RCO_EV_ALM_BASE + {5'h00, c};
                4'h2: slot_index = b + `RCO_EV_PRES;
                4'h3: slot_index = b + `RCO_EV_DISABLE;
                4'h4: slot_index = b + `RCO_EV_ABSENT;
                4'h5: slot_index = b + `RCO_EV_PREDIS;
                4'h6: slot_index = b + `RCO_EV_SUPERV;
                4'h7: slot_index = b + `RCO_EV_ARMING;
                default: slot_index = `RCO_EV_NONE;
            endcase
        end
    endfunction

    function [6:0] map_index;
        input [3:0] mode;
        input [2:0] r;
        reg [31:0] perm;
        reg [1:0] c;
        begin
            c = mode[1:0] - 2'd2;
            case (mode)
                4'h2: perm = `RCO_PERM_2;
                4'h3: perm = `RCO_PERM_3;
                4'h4: perm = `RCO_PERM_4;
                default: perm = `RCO_PERM_5;
            endcase
            case (mode)
                `RCO_MODE_ONE: begin
                    map_index = (r[0] ? `RCO_EV_ALM_BASE : `RCO_EV_TRB_BASE) + {5'h00, r[2:1]};
                end
                4'h2, 4'h3, 4'h4, `RCO_MODE_FIVE: begin
                    map_index = slot_index(perm[{r, 2'b00} +: 4], c);
                end
                `RCO_MODE_SIX: begin
                    case (r)
                        3'd0: map_index = `RCO_EV_SUP_TRB;
                        3'd1: map_index = `RCO_SUP_BASE + 7'd5;
                        3'd2: map_index = `RCO_SUP_BASE + 7'd4;
                        3'd3: map_index = `RCO_SUP_BASE + 7'd3;
                        3'd4: map_index = `RCO_SUP_BASE + 7'd2;
                        3'd5: map_index = `RCO_SUP_BASE + 7'd7;
                        3'd6: map_index = `RCO_EV_NONE;
                        default: map_index = `RCO_EV_BUS_FAIL;
                    endcase
                end
                default: map_index = `RCO_EV_NONE;
            endcase
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg [31:0] init_cnt;
    reg init_done;
    reg [3:0] active_mode;
    reg clear_seen;
    reg [1:0] card_id;
    reg [43:0] ctrl_ev;
    reg [9:0] sup_ev;
    reg [7:0] remote_mask;
    reg [31:0] bus_cnt;
    reg bus_fail;
    reg [7:0] soft_force;
    reg [3:0] profile;
    reg [6:0] pc_map [0:95];
    reg [64:0] ev;
    reg [7:0] next_relay;
    reg cfg_valid;
    reg [6:0] idx;
    reg aw_got;
    reg w_got;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    integer i;
    integer j;

    // ****************************************
    // init, switches and identity
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            init_cnt <= 32'h0000_0000;
            init_done <= 1'b0;
            active_mode <= `RCO_MODE_CLEAR;
            clear_seen <= 1'b0;
            card_id <= 2'b00;
        end else if (!init_done) begin
            init_cnt <= init_cnt + 32'h0000_0001;
            if (init_cnt >= INIT_CYCLES - 32'h0000_0001) begin
                init_done <= 1'b1;
                active_mode <= mode_sw;
                card_id <= addr_sw;
            end
        end else if (mode_sw == `RCO_MODE_CLEAR) begin
            clear_seen <= 1'b1;
        end else if (clear_seen && mode_sw != active_mode) begin
            active_mode <= mode_sw;
            clear_seen <= 1'b0;
        end
    end

    // ****************************************
    // status bus receive and transmit
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ev <= {4{`RCO_CTRL_EV_RST}};
            sup_ev <= `RCO_SUP_EV_RST;
            remote_mask <= 8'h00;
            bus_cnt <= 32'h0000_0000;
            bus_fail <= 1'b0;
            sb_tx_valid <= 1'b0;
            sb_tx_src <= 4'h0;
            sb_tx_data <= 16'h0000;
        end else begin
            if (sb_rx_valid) begin
                bus_cnt <= 32'h0000_0000;
                bus_fail <= 1'b0;
                if (!sb_rx_src[3] && !sb_rx_src[2]) begin
                    ctrl_ev[sb_rx_src[1:0] * `RCO_CTRL_EVS +: `RCO_CTRL_EVS] <=
                        sb_rx_data[10:0];
                end else if (sb_rx_src == `RCO_SRC_SUPPLY) begin
                    sup_ev <= sb_rx_data[9:0];
                end else if (init_done && sb_rx_src == (`RCO_SRC_CARD | {2'b00, card_id})) begin
                    remote_mask <= sb_rx_data[7:0];
                end
            end else if (bus_cnt >= BUS_TIMEOUT - 32'h0000_0001) begin
                bus_fail <= 1'b1;
            end else begin
                bus_cnt <= bus_cnt + 32'h0000_0001;
            end
            sb_tx_valid <= init_done && (next_relay != relay_drive);
            sb_tx_src <= `RCO_SRC_CARD | {2'b00, card_id};
            sb_tx_data <= {8'h00, next_relay};
        end
    end

    // ****************************************
    // event vector and relay decision
    // ****************************************
    always @* begin
        ev = 65'h0;
        ev[43:0] = ctrl_ev;
        ev[53:44] = sup_ev;
        ev[54] = bus_fail;
        for (i = 0; i < 4; i = i + 1) begin
            ev[55 + i] = |(ctrl_ev[i * 11 +: 11] & `RCO_CTRL_TRB_MASK);
            ev[59 + i] = |(ctrl_ev[i * 11 +: 11] & `RCO_CTRL_ALM_MASK);
        end
        ev[63] = |(sup_ev & `RCO_SUP_TRB_MASK);
        ev[64] = supply_low;
        case (active_mode)
            `RCO_MODE_PC: cfg_valid = profile < `RCO_PROFILES;
            `RCO_MODE_ONE, `RCO_MODE_TWO, 4'h3, 4'h4, `RCO_MODE_FIVE, `RCO_MODE_SIX,
            `RCO_MODE_CLEAR: cfg_valid = 1'b1;
            default: cfg_valid = 1'b0;
        endcase
        next_relay = 8'h00;
        idx = `RCO_EV_NONE;
        for (i = 0; i < 8; i = i + 1) begin
            if (active_mode == `RCO_MODE_PC) begin
                idx = pc_map[{profile[3:0], i[2:0]} - {profile[3:0], 3'b000} + profile * 7'd8];
            end else begin
                idx = map_index(active_mode, i[2:0]);
            end
            next_relay[i] = init_done && cfg_valid
                && !(idx <= `RCO_EV_LOW_V && ev[idx])
                && !remote_mask[i] && !soft_force[i];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            relay_drive <= 8'h00;
            relay_led <= 8'h00;
            bus_led <= 1'b0;
        end else begin
            relay_drive <= next_relay;
            relay_led <= next_relay;
            bus_led <= init_done;
        end
    end

    // ****************************************
    // axi4-lite slave
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RCO_RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            soft_force <= 8'h00;
            profile <= 4'h0;
            for (j = 0; j < 96; j = j + 1) begin
                pc_map[j] <= `RCO_EV_NONE;
            end
        end else begin
            s_axi_awready <= !aw_got && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_got && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (aw_got && w_got && !s_axi_bvalid) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RCO_RESP_OKAY;
                if (aw_addr[11:2] == `RCO_REG_FORCE >> 2) begin
                    soft_force <= w_data[7:0];
                end else if (aw_addr[11:2] == `RCO_REG_PROFILE >> 2) begin
                    profile <= w_data[3:0];
                end else if (aw_addr >= `RCO_MAP_BASE && aw_addr < `RCO_MAP_END) begin
                    pc_map[aw_addr[8:2] - 7'h40] <= w_data[6:0];
                end else if (aw_addr[11:2] != `RCO_REG_STATUS >> 2
                    && aw_addr[11:2] != `RCO_REG_EV_LO >> 2
                    && aw_addr[11:2] != `RCO_REG_EV_HI >> 2) begin
                    s_axi_bresp <= `RCO_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RCO_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RCO_RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                if (s_axi_araddr[11:2] == `RCO_REG_FORCE >> 2) begin
                    s_axi_rdata <= {24'h000000, soft_force};
                end else if (s_axi_araddr[11:2] == `RCO_REG_PROFILE >> 2) begin
                    s_axi_rdata <= {28'h0000000, profile};
                end else if (s_axi_araddr[11:2] == `RCO_REG_STATUS >> 2) begin
                    s_axi_rdata <= {15'h0000, card_id, active_mode, !cfg_valid, bus_fail,
                        init_done, relay_drive};
                end else if (s_axi_araddr[11:2] == `RCO_REG_EV_LO >> 2) begin
                    s_axi_rdata <= ev[31:0];
                end else if (s_axi_araddr[11:2] == `RCO_REG_EV_HI >> 2) begin
                    s_axi_rdata <= ev[63:32];
                end else if (s_axi_araddr >= `RCO_MAP_BASE && s_axi_araddr < `RCO_MAP_END) begin
                    s_axi_rdata <= {25'h0000000, pc_map[s_axi_araddr[8:2] - 7'h40]};
                end else begin
                    s_axi_rresp <= `RCO_RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// [hw/rco_defs.vh]
`ifndef RCO_DEFS_VH
`define RCO_DEFS_VH
// ****************************************
// timing
// ****************************************
`define RCO_CLK_HZ 100000000
`define RCO_INIT_S 15
`define RCO_BUS_TIMEOUT_MS 1000
// ****************************************
// register map
// ****************************************
`define RCO_REG_FORCE 12'h000
`define RCO_REG_PROFILE 12'h004
`define RCO_REG_STATUS 12'h008
`define RCO_REG_EV_LO 12'h00c
`define RCO_REG_EV_HI 12'h010
`define RCO_MAP_BASE 12'h100
`define RCO_MAP_END 12'h280
`define RCO_PROFILES 12
`define RCO_RESP_OKAY 2'b00
`define RCO_RESP_SLVERR 2'b10
// ****************************************
// mode switch codes
// ****************************************
`define RCO_MODE_PC 4'h0
`define RCO_MODE_ONE 4'h1
`define RCO_MODE_TWO 4'h2
`define RCO_MODE_FIVE 4'h5
`define RCO_MODE_SIX 4'h6
`define RCO_MODE_CLEAR 4'hf
// ****************************************
// event indices
// ****************************************
`define RCO_CTRL_EVS 11
`define RCO_SUP_BASE 7'd44
`define RCO_EV_BUS_FAIL 7'd54
`define RCO_EV_TRB_BASE 7'd55
`define RCO_EV_ALM_BASE 7'd59
`define RCO_EV_SUP_TRB 7'd63
`define RCO_EV_LOW_V 7'd64
`define RCO_EV_NONE 7'h7f
`define RCO_EV_ABSENT 7'd0
`define RCO_EV_PRES 7'd3
`define RCO_EV_PREDIS 7'd6
`define RCO_EV_SUPERV 7'd7
`define RCO_EV_DISABLE 7'd9
`define RCO_EV_ARMING 7'd10
`define RCO_CTRL_TRB_MASK 11'h6fd
`define RCO_CTRL_ALM_MASK 11'h101
`define RCO_SUP_TRB_MASK 10'h3bd
`define RCO_CTRL_EV_RST 11'h001
`define RCO_SUP_EV_RST 10'h001
// slot order per relay, one nibble per relay, relay 1 lowest
`define RCO_PERM_2 32'h76543210
`define RCO_PERM_3 32'h76541032
`define RCO_PERM_4 32'h76103254
`define RCO_PERM_5 32'h10543276
// ****************************************
// status bus sources
// ****************************************
`define RCO_SRC_SUPPLY 4'h4
`define RCO_SRC_CARD 4'h8
`endif

// [hw/rco_unused_guard.v]
`timescale 1ns/1ps

// [bench/rco_card_sva.sv]
`timescale 1ns/1ps
// ********
// relay card checker
// ********
module rco_card_sva #(
    parameter [31:0] INIT_CYCLES = 32'd20
) (
    // clock, reset, switches
    input wire aclk,
    input wire aresetn,
    input wire [1:0] addr_sw,
    // status bus
    input wire sb_rx_valid,
    input wire [3:0] sb_rx_src,
    input wire [15:0] sb_rx_data,
    input wire sb_tx_valid,
    input wire [3:0] sb_tx_src,
    input wire [15:0] sb_tx_data,
    // relays
    input wire [7:0] relay_drive,
    input wire [7:0] relay_led,
    input wire bus_led,
    // axi read
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [31:0] since_rst;
    // cycles since reset release
    always @(posedge aclk) begin
        if (!aresetn) since_rst <= 32'h0;
        else if (since_rst != 32'hffffffff) since_rst <= since_rst + 32'h1;
    end
    sequence card_cmd;
        sb_rx_valid && bus_led && sb_rx_src == {2'b10, addr_sw} && sb_rx_data[0];
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_reset_dark: assert property ($rose(aresetn) |-> relay_drive == 8'h00 && !bus_led)
        else $error("relays live after reset");
    chk_init_dark: assert property (!bus_led |-> relay_drive == 8'h00)
        else $error("relay energized before init end");
    chk_led_match: assert property (relay_led == relay_drive)
        else $error("relay led differs from relay");
    chk_busled_hold: assert property (bus_led |=> bus_led)
        else $error("bus led dropped");
    chk_init_span: assert property ($rose(bus_led) |->
        since_rst + 32'h1 >= INIT_CYCLES && since_rst <= INIT_CYCLES + 32'h2)
        else $error("init length wrong");
    chk_tx_change: assert property (sb_tx_valid |-> relay_drive != $past(relay_drive))
        else $error("tx pulse without relay change");
    chk_tx_frame: assert property (sb_tx_valid |->
        sb_tx_src == {2'b10, addr_sw} && sb_tx_data == {8'h00, relay_drive})
        else $error("tx frame wrong");
    chk_cmd_drop: assert property (card_cmd |-> ##2 !relay_drive[0])
        else $error("remote drop ignored");
    chk_read_answer: assert property (read_taken |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
endmodule
bind rco_relay_card rco_card_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (
    .aclk, .aresetn, .addr_sw, .sb_rx_valid, .sb_rx_src, .sb_rx_data, .sb_tx_valid,
    .sb_tx_src, .sb_tx_data, .relay_drive, .relay_led, .bus_led, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// [bench/rco_bus_partner.sv]
`timescale 1ns/1ps
// ********
// controllers and supply unit on the status bus
// ********
module rco_bus_partner (
    // clock
    input wire aclk,
    // frames to the card
    output logic sb_rx_valid,
    output logic [3:0] sb_rx_src,
    output logic [15:0] sb_rx_data
);
    logic [10:0] held [0:3];
    logic [3:0] rdis;
    initial begin
        sb_rx_valid = 1'b0;
        sb_rx_src = 4'h0;
        sb_rx_data = 16'h0;
        rdis = 4'h0;
        for (int i = 0; i < 4; i++) held[i] = 11'h0;
    end
    // idle lines show the inverse of the last frame
    task send(input logic [3:0] s, input logic [15:0] d);
        sb_rx_valid <= 1'b1;
        sb_rx_src <= s;
        sb_rx_data <= d;
        @(posedge aclk);
        sb_rx_valid <= 1'b0;
        sb_rx_src <= ~s;
        sb_rx_data <= ~d;
        @(posedge aclk);
    endtask
    task ctrl(input int c, input logic [10:0] b);
        logic [10:0] f;
        held[c] = held[c] | (b & 11'h4fc);
        f = b | held[c] | {1'b0, rdis[c], 9'h0};
        if ((f & 11'h6fc) != 11'h0) f[1] = 1'b0;
        send({2'b00, c[1:0]}, {5'h00, f});
    endtask
    task power_cycle(input int c);
        held[c] = 11'h0;
    endtask
    task set_disable(input int c, input logic on);
        rdis[c] = on;
        ctrl(c, 11'h002);
    endtask
endmodule

// [bench/test_relay_status_output_card.sv]
`timescale 1ns/1ps
// ********
// relay card bench
// ********
module test_relay_status_output_card;
    logic aclk, aresetn, supply_low, bus_led, sb_rx_valid, sb_tx_valid;
    logic [3:0] mode_sw, sb_rx_src, sb_tx_src, s_axi_wstrb;
    logic [1:0] addr_sw, s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] sb_rx_data, sb_tx_data;
    logic [7:0] relay_drive, relay_led;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int bad_count, checks;
    rco_relay_card #(.INIT_CYCLES(32'd20), .BUS_TIMEOUT(32'd90000)) DUT (
        .aclk, .aresetn, .mode_sw, .addr_sw, .supply_low, .sb_rx_valid, .sb_rx_src,
        .sb_rx_data, .sb_tx_valid, .sb_tx_src, .sb_tx_data, .relay_drive, .relay_led,
        .bus_led, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rco_bus_partner peer (.aclk, .sb_rx_valid, .sb_rx_src, .sb_rx_data);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
        if (n >= 200) bad_count++;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task rd_reg(input logic [11:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
        if (n >= 200) bad_count++;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task t_init;
        int n;
        n = 0;
        while (bus_led !== 1'b1 && n < 100) begin
            chk("dark", relay_drive, 8'h00);
            @(posedge aclk);
            n++;
        end
        chk("init_len", n >= 18 && n <= 23, 1);
        cyc(2);
        chk("normal", relay_drive, 8'hff);
        chk("leds", relay_led, 8'hff);
    endtask
    task t_map;
        wr(12'h100, 32'h2);
        rd_reg(12'h100);
        chk("map", rd, 32'h2);
        peer.ctrl(0, 11'h004);
        cyc(2);
        chk("in_trb", relay_drive, 8'hfe);
        peer.power_cycle(0);
        peer.ctrl(0, 11'h002);
        cyc(2);
        chk("recover", relay_drive, 8'hff);
        wr(12'h104, 32'd64);
        supply_low <= 1'b1;
        cyc(3);
        chk("low_v", relay_drive, 8'hfd);
        supply_low <= 1'b0;
        wr(12'h108, 32'd47);
        peer.send(4'h4, 16'h0008);
        cyc(2);
        chk("ground", relay_drive, 8'hfb);
        peer.send(4'h4, 16'h0002);
        cyc(2);
        chk("sup_ok", relay_drive, 8'hff);
    endtask
    task t_remote;
        peer.send(4'h9, 16'h00ff);
        cyc(2);
        chk("other_id", relay_drive, 8'hff);
        peer.send(4'ha, 16'h0081);
        cyc(2);
        chk("remote", relay_drive, 8'h7e);
        peer.send(4'ha, 16'h0000);
        cyc(2);
        chk("release", relay_drive, 8'hff);
    endtask
    task t_prof;
        wr(12'h004, 32'd12);
        cyc(2);
        chk("bad_prof", relay_drive, 8'h00);
        wr(12'h004, 32'd11);
        rd_reg(12'h004);
        chk("prof", rd, 32'd11);
        chk("prof_on", relay_drive, 8'hff);
        rd_reg(12'h014);
        chk("unmapped", rs, 2'b10);
        wr(12'h004, 32'd0);
    endtask
    task t_mode;
        mode_sw <= 4'h1;
        cyc(4);
        rd_reg(12'h008);
        chk("one_sw", rd[14:11], 4'h0);
        mode_sw <= 4'hf;
        cyc(4);
        mode_sw <= 4'h1;
        cyc(4);
        rd_reg(12'h008);
        chk("mode", rd[14:11], 4'h1);
        chk("card_id", rd[16:15], 2'b10);
        for (int c = 1; c < 4; c++) peer.ctrl(c, 11'h002);
        cyc(2);
        chk("mode1_ok", relay_drive, 8'hff);
        peer.ctrl(1, 11'h008);
        cyc(2);
        chk("pres", relay_drive, 8'hfb);
        peer.set_disable(0, 1'b1);
        cyc(2);
        chk("rdis", relay_drive, 8'hfa);
        peer.set_disable(0, 1'b0);
        cyc(2);
        chk("rdis_off", relay_drive, 8'hfb);
    endtask
    initial begin
        aresetn = 1'b0;
        mode_sw = 4'h0;
        addr_sw = 2'b10;
        supply_low = 1'b0;
        s_axi_awaddr = 12'h0;
        s_axi_araddr = 12'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        bad_count = 0;
        checks = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_init;
        t_map;
        t_remote;
        t_prof;
        t_mode;
        test_done;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        test_done;
    end
endmodule
